/* File: pkg/sfs_pkg.sv */
// Constants and types shared by the serial flash status and map logic.
package sfs_pkg;
	localparam int CLK_MHZ = 50;
	localparam int PROG_TIME_US = 1500;
	localparam int SECT_ERASE_US = 150000;
	localparam int BLOCK_ERASE_US = 750000;
	localparam int CHIP_ERASE_US = 2000000;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int SECT_ERASE_CYC = SECT_ERASE_US * CLK_MHZ;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
	localparam int TMR_W = 27;

	localparam int PAGE_COUNT = 1024;
	localparam int PAGE_BYTES = 256;
	localparam int SECTOR_COUNT = 64;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLOCK_COUNT = 4;
	localparam int BLOCK_BYTES = 65536;
	localparam int ARR_AW = 18;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 16;

	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h60;

	localparam logic [2:0] LEN_SHORT = 3'h1;
	localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
	localparam logic [2:0] LEN_ERASE = 3'h4;
	localparam logic [2:0] LEN_PROG_MIN = 3'h5;
	localparam logic [2:0] LEN_ADDR_LAST = 3'h3;
	localparam logic [2:0] LEN_SAT = 3'h7;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [4:0] PIN_RST = 5'h0B;

	typedef struct packed {
		logic protect_lock;
		logic reserved;
		logic protect_end_select;
		logic protect_level_bit_two;
		logic protect_level_bit_one;
		logic protect_level_bit_zero;
		logic write_enable_latch;
		logic busy;
	} sfs_status_t;

	typedef struct packed {
		logic sck;
		logic sel_n;
		logic si;
		logic hold_n;
		logic guard_n;
	} sfs_pins_t;

	typedef enum logic [1:0] {
		ARR_PROG = 2'h0,
		ARR_ERASE_SECTOR = 2'h1,
		ARR_ERASE_BLOCK = 2'h2,
		ARR_ERASE_CHIP = 2'h3
	} sfs_arr_kind_t;

	typedef struct packed {
		sfs_arr_kind_t kind;
		logic [ARR_AW-1:0] addr;
		logic [7:0] data;
	} sfs_arr_req_t;

	typedef enum logic [1:0] {
		RX_OPCODE = 2'h0,
		RX_ADDR = 2'h1,
		RX_DATA = 2'h3,
		RX_DROP = 2'h2
	} sfs_rx_state_t;
endpackage : sfs_pkg

/* File: logic/sfs_pin_sync.sv */
// Three-stage pin synchroniser that passes a bit once stages two and three agree.
`timescale 1ns/10ps
module sfs_pin_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic out_ff;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					s1_ff <= RST_VAL[gi];
					s2_ff <= RST_VAL[gi];
					s3_ff <= RST_VAL[gi];
					out_ff <= RST_VAL[gi];
				end else if (clk_en) begin
					s1_ff <= din[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff) begin
						out_ff <= s3_ff;
					end
				end
			end
			assign dout[gi] = out_ff;
		end
	endgenerate
endmodule : sfs_pin_sync

/* File: logic/sfs_protect.sv */
// Decodes the protect level and end select into a per-address protect flag.
`timescale 1ns/10ps
module sfs_protect (
	input wire logic [2:0] level,
	input wire logic end_select,
	input wire logic [sfs_pkg::ARR_AW-1:0] addr,
	output logic hit
);
	logic [2:0] quarters;
	logic [1:0] blk;

	assign blk = addr[sfs_pkg::ARR_AW-1:sfs_pkg::BLOCK_LSB];

	// Codes outside the decode table protect nothing.
	always_comb begin
		unique case (level)
			3'h1: quarters = 3'h1;
			3'h2: quarters = 3'h2;
			3'h6: quarters = 3'h3;
			3'h3, 3'h7: quarters = 3'h4;
			default: quarters = 3'h0;
		endcase
	end

	// Region grows down from the top with select low, up from zero when high.
	always_comb begin
		if (end_select) begin
			hit = ({1'b0, blk} < quarters);
		end else begin
			hit = ({1'b0, blk} >= (3'h4 - quarters)) && (quarters != 3'h0);
		end
	end
endmodule : sfs_protect

/* File: logic/sfs_status_map.sv */
// Serial port front end, status register and write state of the flash.
//
// Contract
// - Command, address and data bits are captured at serial clock rise.
// - Outgoing serial bits change at serial clock fall.
// - Port answers only while select is low; host holds it low throughout.
// - Hold pauses the transfer without losing internal state.
// - Serial port works in SPI mode 0 and mode 3.
// - Array is 1,024 pages of 256 bytes; program takes 1 to 256 bytes.
// - Array splits into 64 sectors of 4K and 4 blocks of 64K.
// - Erasing one sector or block leaves all others untouched.
// - Erase exists only per sector, block or whole chip, never per page.
// - Status bit 0 shows busy; read only; zero at power-up.
// - Status bit 1 shows the write enable latch; read only; zero at power-up.
// - Status bits 2 to 4 are writable protect level bits, zero default.
// - Status bit 5 is the writable protect end select, zero default.
// - Status bit 6 is reserved, reads zero, ignores writes.
// - Protect lock at 1 freezes protect level and end select while the guard pin is low.
// - Status write alters only protect level, end select and lock.
// - Protect level, end select and lock survive power cycles.
// - With the latch clear, program and erase commands are ignored.
// - Latch clears at power-up, disable, program, erases and status write.
// - Status write refused when guard pin low and lock set.
// - End select picks top or bottom; levels give none to all quarters.
// - Chip erase runs only when all protect level bits are zero.
`timescale 1ns/10ps
module sfs_status_map #(
	parameter int PROG_CYCLES = sfs_pkg::PROG_CYC,
	parameter int SECT_CYCLES = sfs_pkg::SECT_ERASE_CYC,
	parameter int BLOCK_CYCLES = sfs_pkg::BLOCK_ERASE_CYC,
	parameter int CHIP_CYCLES = sfs_pkg::CHIP_ERASE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic pin_sck,
	input wire logic pin_sel_n,
	input wire logic pin_si,
	input wire logic pin_hold_n,
	input wire logic pin_guard_n,
	output logic pin_so,
	output logic pin_so_oe,
	input wire logic [4:0] nv_restore,
	output logic [4:0] nv_image,
	output sfs_pkg::sfs_status_t status_view,
	output sfs_pkg::sfs_arr_req_t arr_req,
	output logic arr_strobe
);
	sfs_pkg::sfs_pins_t pins_s;
	sfs_pkg::sfs_rx_state_t rx_state_ff;
	sfs_pkg::sfs_arr_req_t arr_req_ff;
	logic sck_d_ff, sel_d_ff, hold_ff, rdsr_ff, wrote_ff, so_ff, arr_strobe_ff;
	logic we_latch_ff, lock_ff, end_sel_ff;
	logic [2:0] level_ff, bit_cnt_ff, byte_cnt_ff;
	logic [6:0] rx_shift_ff, tx_shift_ff;
	logic [7:0] opcode_ff, sr_data_ff, rx_byte;
	logic [23:0] addr_ff;
	logic [sfs_pkg::TMR_W-1:0] tmr_ff;
	logic active, sck_rise, sck_fall, frame_end, edge_ok, byte_done, busy;
	logic prot_hit, framed, sr_write_ok, erase_go, chip_go;
	logic [sfs_pkg::ARR_AW-1:0] arr_addr;

	// Three sync flops and an output flop per pin; the link clock is sampled, not used as a clock.
	sfs_pin_sync #(
		.W(5),
		.RST_VAL(sfs_pkg::PIN_RST)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.din({pin_sck, pin_sel_n, pin_si, pin_hold_n, pin_guard_n}),
		.dout(pins_s)
	);

	assign arr_addr = addr_ff[sfs_pkg::ARR_AW-1:0];

	sfs_protect u_prot (
		.level(level_ff),
		.end_select(end_sel_ff),
		.addr(arr_addr),
		.hit(prot_hit)
	);

	assign active = !pins_s.sel_n;
	assign sck_rise = pins_s.sck && !sck_d_ff;
	assign sck_fall = !pins_s.sck && sck_d_ff;
	assign frame_end = pins_s.sel_n && !sel_d_ff;
	assign edge_ok = active && !hold_ff;
	assign byte_done = edge_ok && sck_rise && (bit_cnt_ff == 3'h7);
	assign rx_byte = {rx_shift_ff, pins_s.si};
	assign busy = (tmr_ff != '0);

	// A command counts only if it ended on a byte boundary at its length.
	always_comb begin
		framed = 1'b0;
		if (bit_cnt_ff == 3'h0) begin
			unique case (opcode_ff)
				sfs_pkg::OP_WRITE_ENABLE, sfs_pkg::OP_WRITE_DISABLE,
				sfs_pkg::OP_CHIP_ERASE: framed = (byte_cnt_ff == sfs_pkg::LEN_SHORT);
				sfs_pkg::OP_STATUS_WRITE:
					framed = (byte_cnt_ff == sfs_pkg::LEN_STATUS_WRITE);
				sfs_pkg::OP_SECT_ERASE, sfs_pkg::OP_BLOCK_ERASE:
					framed = (byte_cnt_ff == sfs_pkg::LEN_ERASE);
				sfs_pkg::OP_PAGE_PROG: framed = (byte_cnt_ff >= sfs_pkg::LEN_PROG_MIN);
				default: framed = 1'b0;
			endcase
		end
	end

	// The lock only bites while the guard pin is low.
	assign sr_write_ok = frame_end && framed && !busy && we_latch_ff
		&& (opcode_ff == sfs_pkg::OP_STATUS_WRITE)
		&& (pins_s.guard_n || !lock_ff);
	assign erase_go = frame_end && framed && !busy && we_latch_ff && !prot_hit
		&& ((opcode_ff == sfs_pkg::OP_SECT_ERASE)
		|| (opcode_ff == sfs_pkg::OP_BLOCK_ERASE));
	assign chip_go = frame_end && framed && !busy && we_latch_ff
		&& (opcode_ff == sfs_pkg::OP_CHIP_ERASE)
		&& (level_ff == 3'h0);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sck_d_ff <= 1'b0;
			sel_d_ff <= 1'b1;
		end else if (clk_en) begin
			sck_d_ff <= pins_s.sck;
			sel_d_ff <= pins_s.sel_n;
		end
	end

	// Hold takes effect and releases only while the serial clock is low.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_ff <= 1'b0;
		end else if (clk_en) begin
			if (!active) begin
				hold_ff <= 1'b0;
			end else if (!pins_s.sck) begin
				hold_ff <= !pins_s.hold_n;
			end
		end
	end

	// Receive side: bits shift in on every accepted rising edge.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bit_cnt_ff <= 3'h0;
			rx_shift_ff <= 7'h00;
		end else if (clk_en) begin
			if (!active) begin
				bit_cnt_ff <= 3'h0;
			end else if (edge_ok && sck_rise) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				rx_shift_ff <= rx_byte[6:0];
			end
		end
	end

	// Byte count is kept through the frame end so that framing can be judged.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			byte_cnt_ff <= 3'h0;
			rx_state_ff <= sfs_pkg::RX_OPCODE;
			opcode_ff <= 8'h00;
			addr_ff <= 24'h000000;
			sr_data_ff <= 8'h00;
			rdsr_ff <= 1'b0;
		end else if (clk_en) begin
			if (!active) begin
				if (frame_end) begin
					byte_cnt_ff <= byte_cnt_ff;
				end else begin
					byte_cnt_ff <= 3'h0;
				end
				rx_state_ff <= sfs_pkg::RX_OPCODE;
				rdsr_ff <= 1'b0;
			end else if (byte_done) begin
				if (byte_cnt_ff != sfs_pkg::LEN_SAT) begin
					byte_cnt_ff <= byte_cnt_ff + 3'h1;
				end
				unique case (rx_state_ff)
					sfs_pkg::RX_OPCODE: begin
						opcode_ff <= rx_byte;
						rdsr_ff <= (rx_byte == sfs_pkg::OP_STATUS_READ);
						// Busy drops all but a status poll.
						if (busy) begin
							rx_state_ff <= sfs_pkg::RX_DROP;
						end else if (rx_byte == sfs_pkg::OP_STATUS_WRITE) begin
							rx_state_ff <= sfs_pkg::RX_DATA;
						end else if ((rx_byte == sfs_pkg::OP_PAGE_PROG)
							|| (rx_byte == sfs_pkg::OP_SECT_ERASE)
							|| (rx_byte == sfs_pkg::OP_BLOCK_ERASE)) begin
							rx_state_ff <= sfs_pkg::RX_ADDR;
						end else begin
							rx_state_ff <= sfs_pkg::RX_DROP;
						end
					end
					sfs_pkg::RX_ADDR: begin
						addr_ff <= {addr_ff[15:0], rx_byte};
						if (byte_cnt_ff == sfs_pkg::LEN_ADDR_LAST) begin
							rx_state_ff <= (opcode_ff == sfs_pkg::OP_PAGE_PROG)
								? sfs_pkg::RX_DATA : sfs_pkg::RX_DROP;
						end
					end
					sfs_pkg::RX_DATA: begin
						if (opcode_ff == sfs_pkg::OP_STATUS_WRITE) begin
							sr_data_ff <= rx_byte;
						end else begin
							// Address wraps inside the page, never across it.
							addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
						end
					end
					sfs_pkg::RX_DROP: begin
						rx_state_ff <= sfs_pkg::RX_DROP;
					end
				endcase
			end
		end
	end

	// Array requests; program bytes go out as they arrive.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			arr_strobe_ff <= 1'b0;
			arr_req_ff <= '0;
			wrote_ff <= 1'b0;
		end else if (clk_en) begin
			arr_strobe_ff <= 1'b0;
			if (!active && !frame_end) begin
				wrote_ff <= 1'b0;
			end
			if (byte_done && (rx_state_ff == sfs_pkg::RX_DATA)
				&& (opcode_ff == sfs_pkg::OP_PAGE_PROG)
				&& we_latch_ff && !prot_hit) begin
				arr_strobe_ff <= 1'b1;
				wrote_ff <= 1'b1;
				arr_req_ff <= '{sfs_pkg::ARR_PROG, arr_addr, rx_byte};
			end else if (erase_go) begin
				arr_strobe_ff <= 1'b1;
				if (opcode_ff == sfs_pkg::OP_SECT_ERASE) begin
					arr_req_ff <= '{sfs_pkg::ARR_ERASE_SECTOR,
						{arr_addr[17:sfs_pkg::SECTOR_LSB], 12'h000}, 8'h00};
				end else begin
					arr_req_ff <= '{sfs_pkg::ARR_ERASE_BLOCK,
						{arr_addr[17:sfs_pkg::BLOCK_LSB], 16'h0000}, 8'h00};
				end
			end else if (chip_go) begin
				arr_strobe_ff <= 1'b1;
				arr_req_ff <= '{sfs_pkg::ARR_ERASE_CHIP, '0, 8'h00};
			end
		end
	end

	// Busy timer starts when the frame that ran an operation closes.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tmr_ff <= '0;
		end else if (clk_en) begin
			if (frame_end && framed && wrote_ff && !busy
				&& (opcode_ff == sfs_pkg::OP_PAGE_PROG)) begin
				tmr_ff <= sfs_pkg::TMR_W'(PROG_CYCLES);
			end else if (erase_go || chip_go) begin
				if (chip_go) begin
					tmr_ff <= sfs_pkg::TMR_W'(CHIP_CYCLES);
				end else if (opcode_ff == sfs_pkg::OP_SECT_ERASE) begin
					tmr_ff <= sfs_pkg::TMR_W'(SECT_CYCLES);
				end else begin
					tmr_ff <= sfs_pkg::TMR_W'(BLOCK_CYCLES);
				end
			end else if (busy) begin
				tmr_ff <= tmr_ff - sfs_pkg::TMR_W'(1);
			end
		end
	end

	// Write enable latch.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			we_latch_ff <= 1'b0;
		end else if (clk_en && frame_end && framed && !busy) begin
			if (opcode_ff == sfs_pkg::OP_WRITE_ENABLE) begin
				we_latch_ff <= 1'b1;
			end else begin
				we_latch_ff <= 1'b0;
			end
		end
	end

	// Retained bits reload from the outside store at power-up.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{lock_ff, end_sel_ff, level_ff} <= nv_restore;
		end else if (clk_en && sr_write_ok) begin
			lock_ff <= sr_data_ff[7];
			if (!lock_ff || pins_s.guard_n) begin
				end_sel_ff <= sr_data_ff[5];
				level_ff <= sr_data_ff[4:2];
			end
		end
	end

	assign nv_image = {lock_ff, end_sel_ff, level_ff};
	assign status_view = '{lock_ff, 1'b0, end_sel_ff, level_ff[2], level_ff[1],
		level_ff[0], we_latch_ff, busy};

	// Transmit side: status bytes repeat while select stays low.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			so_ff <= 1'b0;
			tx_shift_ff <= 7'h00;
		end else if (clk_en && edge_ok && sck_fall && rdsr_ff) begin
			if (bit_cnt_ff == 3'h0) begin
				{so_ff, tx_shift_ff} <= status_view;
			end else begin
				{so_ff, tx_shift_ff} <= {tx_shift_ff, 1'b0};
			end
		end
	end

	assign pin_so = so_ff;
	assign pin_so_oe = edge_ok && rdsr_ff;
	assign arr_req = arr_req_ff;
	assign arr_strobe = arr_strobe_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_so_select: assert property (pin_so_oe |-> !pins_s.sel_n && !hold_ff)
		else $error("Serial output driven while deselected or held.");
	chk_so_fall_edge: assert property (clk_en && !(sck_fall && edge_ok)
		|=> $stable(so_ff))
		else $error("Serial output changed outside a falling edge.");
	chk_rx_rise_edge: assert property (clk_en && edge_ok && sck_rise
		|=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
		else $error("Rising edge did not advance the bit count.");
	chk_latch_set_cmd: assert property (clk_en && frame_end && framed && !busy
		&& opcode_ff == sfs_pkg::OP_WRITE_ENABLE |=> we_latch_ff)
		else $error("Enable command failed to set the latch.");
	chk_latch_clear_cmd: assert property (clk_en && frame_end && framed
		&& !busy && opcode_ff != sfs_pkg::OP_WRITE_ENABLE
		|=> !we_latch_ff)
		else $error("Latch not cleared after a completed command.");
	chk_reserved_zero: assert property (status_view.reserved == 1'b0)
		else $error("Reserved status bit reads non-zero.");
	chk_strobe_needs_latch: assert property (arr_strobe
		|-> $past(we_latch_ff))
		else $error("Array operation issued with the latch clear.");
	chk_chip_erase_lvl: assert property (arr_strobe
		&& arr_req.kind == sfs_pkg::ARR_ERASE_CHIP |-> $past(level_ff) == 3'h0)
		else $error("Chip erase issued with protection set.");
	chk_guard_lock: assert property (clk_en && !pins_s.guard_n && lock_ff
		|=> $stable(nv_image))
		else $error("Locked status bits changed with guard low.");
	chk_erase_busy: assert property (arr_strobe
		&& arr_req.kind != sfs_pkg::ARR_PROG |-> busy ##1 busy)
		else $error("Erase issued without raising busy.");
	chk_hold_freeze: assert property (clk_en && hold_ff && active
		|=> $stable(bit_cnt_ff) && $stable(rx_state_ff))
		else $error("Receive state moved during hold.");
endmodule : sfs_status_map

/* File: test/sfs_host.sv */
// Serial host model that frames commands on the flash pins.
`timescale 1ns/10ps
module sfs_host (
	input wire logic core_clk,
	output logic sck,
	output logic sel_n,
	output logic si,
	output logic hold_n,
	input wire logic so
);
	logic idle;
	initial begin
		idle = 1'b0;
		sck = 1'b0;
		sel_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	// Clock level between frames: low for mode 0, high for mode 3.
	task automatic set_idle(input logic v);
		idle = v;
		sck = v;
		tick(8);
	endtask : set_idle
	// Select falls with the clock at its idle level, low for mode 0 and high for mode 3.
	task automatic frame_open();
		sel_n = 1'b0;
		tick(4);
	endtask : frame_open
	// Data changes while the clock is low and is held over the rise.
	// Reply bits are taken late in the high phase, because the pin
	// synchroniser delays the fall that launches them.
	task automatic xfer(input logic [7:0] tx, input bit pause,
			output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			tick(4);
			if (pause && i == 4) begin
				hold_n = 1'b0;
				tick(4);
				si = ~si;
				repeat (2) begin
					sck = 1'b1;
					tick(4);
					sck = 1'b0;
					tick(4);
				end
				si = tx[i];
				hold_n = 1'b1;
				tick(4);
			end
			sck = 1'b1;
			tick(4);
			rx[i] = so;
		end
	endtask : xfer
	// The clock returns to idle before select rises, so frames stay whole.
	task automatic frame_close();
		sck = idle;
		tick(4);
		sel_n = 1'b1;
		si = ~si;
		tick(12);
	endtask : frame_close
endmodule : sfs_host

/* File: test/sfs_status_map_test.sv */
// Self-checking bench for the flash status and map block.
`timescale 1ns/10ps
module sfs_status_map_test;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic guard_n = 1'b1;
	logic [4:0] nv_restore = 5'h00;
	logic sck;
	logic sel_n;
	logic si;
	logic hold_n;
	logic pin_so;
	logic so_oe;
	logic so_line;
	logic [4:0] nv_image;
	sfs_pkg::sfs_status_t status_view;
	sfs_pkg::sfs_arr_req_t arr_req;
	sfs_pkg::sfs_arr_req_t last_req;
	logic arr_strobe;
	logic [7:0] s;
	int num_errors = 0;
	int compares = 0;
	int strobes = 0;
	int cycles = 0;

	initial begin
		forever #10 core_clk = ~core_clk;
	end

	// Short busy times keep the run brief; waits poll rather than count.
	sfs_status_map #(
		.PROG_CYCLES(300),
		.SECT_CYCLES(300),
		.BLOCK_CYCLES(300),
		.CHIP_CYCLES(300)
	) u_sfs_status_map (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.pin_sck(sck),
		.pin_sel_n(sel_n),
		.pin_si(si),
		.pin_hold_n(hold_n),
		.pin_guard_n(guard_n),
		.pin_so(pin_so),
		.pin_so_oe(so_oe),
		.nv_restore(nv_restore),
		.nv_image(nv_image),
		.status_view(status_view),
		.arr_req(arr_req),
		.arr_strobe(arr_strobe)
	);

	// A released output shows the inverse of its last bit, so a read taken
	// while the enable is low cannot pass by accident.
	assign so_line = so_oe ? pin_so : !pin_so;

	sfs_host u_sfs_host (
		.core_clk(core_clk),
		.sck(sck),
		.sel_n(sel_n),
		.si(si),
		.hold_n(hold_n),
		.so(so_line)
	);

	always @(posedge core_clk) begin
		cycles++;
		if (arr_strobe === 1'b1) begin
			strobes++;
			last_req <= arr_req;
		end
		if (cycles == 30000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reset(input logic [4:0] nv);
		@(negedge core_clk);
		rst = 1'b1;
		nv_restore = nv;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : reset

	task automatic cmd(input logic [7:0] op);
		u_sfs_host.frame_open();
		u_sfs_host.xfer(op, 1'b0, s);
		u_sfs_host.frame_close();
	endtask : cmd

	task automatic status_write(input logic [7:0] v);
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		u_sfs_host.frame_open();
		u_sfs_host.xfer(sfs_pkg::OP_STATUS_WRITE, 1'b0, s);
		u_sfs_host.xfer(v, 1'b0, s);
		u_sfs_host.frame_close();
	endtask : status_write

	task automatic rdsr(input bit pause);
		u_sfs_host.frame_open();
		u_sfs_host.xfer(sfs_pkg::OP_STATUS_READ, 1'b0, s);
		u_sfs_host.xfer(8'h00, pause, s);
		u_sfs_host.frame_close();
	endtask : rdsr

	// Address goes out top byte first; data bytes count up from d.
	task automatic op_at(input logic [7:0] op, input logic [17:0] a,
			input int n, input logic [7:0] d, input bit we);
		if (we) cmd(sfs_pkg::OP_WRITE_ENABLE);
		u_sfs_host.frame_open();
		u_sfs_host.xfer(op, 1'b0, s);
		u_sfs_host.xfer({6'h00, a[17:16]}, 1'b0, s);
		u_sfs_host.xfer(a[15:8], 1'b0, s);
		u_sfs_host.xfer(a[7:0], 1'b0, s);
		for (int i = 0; i < n; i++) begin
			u_sfs_host.xfer(d + 8'(i), 1'b0, s);
		end
		u_sfs_host.frame_close();
	endtask : op_at

	// While busy the host sends nothing but status reads.
	task automatic wait_ready();
		for (int i = 0; i < 20; i++) begin
			rdsr(1'b0);
			if (s[0] === 1'b0) break;
		end
		check(32'(s[0]), 32'h0);
	endtask : wait_ready

	initial begin
		reset(5'h1F);
		check(32'(status_view), 32'hBC);
		check(32'(nv_image), 32'h1F);
		reset(5'h00);
		check(32'(status_view), 32'h00);
		rdsr(1'b0);
		check(32'(s), 32'h00);
		$display("test reset done");
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		rdsr(1'b1);
		check(32'(s), 32'h02);
		cmd(sfs_pkg::OP_WRITE_DISABLE);
		check(32'(so_oe), 32'h0);
		rdsr(1'b0);
		check(32'(s), 32'h00);
		// A frame sent while the clock enable is low must leave no trace.
		clk_en = 1'b0;
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		clk_en = 1'b1;
		rdsr(1'b0);
		check(32'(s), 32'h00);
		status_write(8'hFF);
		rdsr(1'b0);
		check(32'(s), 32'hBC);
		guard_n = 1'b0;
		status_write(8'h00);
		check(32'(status_view & 8'hFC), 32'hBC);
		guard_n = 1'b1;
		status_write(8'h04);
		check(32'(status_view), 32'h04);
		$display("test status done");
		op_at(sfs_pkg::OP_PAGE_PROG, 18'h30000, 1, 8'hA5, 1'b1);
		check(32'(strobes), 32'd0);
		op_at(sfs_pkg::OP_PAGE_PROG, 18'h200FF, 2, 8'hA5, 1'b1);
		rdsr(1'b0);
		check(32'(s & 8'hFD), 32'h05);
		check(32'(strobes), 32'd2);
		check(32'(last_req), {4'h0, 2'h0, 18'h20000, 8'hA6});
		wait_ready();
		check(32'(s), 32'h04);
		op_at(sfs_pkg::OP_SECT_ERASE, 18'h12345, 0, 8'h00, 1'b0);
		check(32'(strobes), 32'd2);
		op_at(sfs_pkg::OP_SECT_ERASE, 18'h12345, 0, 8'h00, 1'b1);
		check(32'(last_req[27:8]), {12'h0, 2'h1, 18'h12000});
		wait_ready();
		op_at(sfs_pkg::OP_BLOCK_ERASE, 18'h23456, 0, 8'h00, 1'b1);
		check(32'(last_req[27:8]), {12'h0, 2'h2, 18'h20000});
		wait_ready();
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		cmd(sfs_pkg::OP_CHIP_ERASE);
		check(32'(strobes), 32'd4);
		status_write(8'h24);
		op_at(sfs_pkg::OP_PAGE_PROG, 18'h0FFFF, 1, 8'h5A, 1'b1);
		check(32'(strobes), 32'd4);
		op_at(sfs_pkg::OP_PAGE_PROG, 18'h10000, 1, 8'h5A, 1'b1);
		check(32'(strobes), 32'd5);
		wait_ready();
		status_write(8'h00);
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		cmd(sfs_pkg::OP_CHIP_ERASE);
		check(32'(last_req[27:8]), {12'h0, 2'h3, 18'h00000});
		wait_ready();
		$display("test array done");
		u_sfs_host.set_idle(1'b1);
		cmd(sfs_pkg::OP_WRITE_ENABLE);
		rdsr(1'b0);
		check(32'(s), 32'h02);
		u_sfs_host.set_idle(1'b0);
		$display("test mode three done");
		end_of_test();
	end
endmodule : sfs_status_map_test
